//--- src/scpi_regs.svh
`ifndef SCPI_REGS_SVH
`define SCPI_REGS_SVH
// frame and field layout
`define SCPI_FRAME_BITS 5'd16
`define SCPI_LAST_BIT 4'hF
`define SCPI_DIR_BIT 0
`define SCPI_DIR_WRITE 1'b0
`define SCPI_DIR_READ 1'b1
`define SCPI_DIR_SPONT 1'b0
`define SCPI_IDLE_BYTE 8'h00
// queue depth (log2)
`define SCPI_QUEUE_AW 3
`endif

//--- src/scpi_pkg.sv
package scpi_pkg;
  typedef enum logic [2:0] {
    SCPI_IDLE = 3'b001,
    SCPI_SHIFT = 3'b010,
    SCPI_WAIT = 3'b100
  } scpi_state_t;
  typedef logic [6:0] scpi_index_t;
  typedef logic [7:0] scpi_byte_t;
endpackage : scpi_pkg

//--- src/scpi_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a group of level inputs
module scpi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : scpi_sync

//--- src/scpi_port.sv
`timescale 1ns/1ps
`include "scpi_regs.svh"
module scpi_port #(
  parameter int QUEUE_AW = `SCPI_QUEUE_AW
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic port_type_select_i,
  input wire logic select_n_i,
  input wire logic ctrl_shift_clock_i,
  input wire logic ctrl_serial_in_i,
  output logic ctrl_serial_out_o,
  output logic ctrl_serial_out_oe_o,
  output logic irq_n_out_o,
  output logic irq_n_oe_o,
  // register write strobe to the device core
  output logic wr_valid_o,
  output scpi_pkg::scpi_index_t wr_index_o,
  output scpi_pkg::scpi_byte_t wr_data_o,
  // read-back request strobe to the device core
  output logic rb_req_valid_o,
  output scpi_pkg::scpi_index_t rb_req_index_o,
  // message push from the device core
  input wire logic msg_valid_i,
  input wire logic msg_readback_i,
  input wire scpi_pkg::scpi_index_t msg_index_i,
  input wire scpi_pkg::scpi_byte_t msg_data_i,
  output logic msg_ready_o
);
  import scpi_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pins_s;
  scpi_sync #(.WIDTH(4)) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({port_type_select_i, select_n_i, ctrl_shift_clock_i, ctrl_serial_in_i}),
    .sync_o(pins_s)
  );
  wire mode_s = pins_s[3];
  wire sel_n_s = pins_s[2];
  wire sck_s = pins_s[1];
  wire sdi_s = pins_s[0];

  // ----------------------------------------
  // pin edge detection
  // ----------------------------------------
  logic sck_d;
  logic sel_n_d;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      sck_d <= 1'b0;
      sel_n_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      sel_n_d <= sel_n_s;
    end
  end

  wire active = mode_s & ~sel_n_s;
  wire sck_rise = active & sck_s & ~sck_d;
  wire sck_fall = active & ~sck_s & sck_d;
  wire sel_fall = mode_s & ~sel_n_s & sel_n_d;
  wire sel_rise = sel_n_s & ~sel_n_d;

  // ----------------------------------------
  // message queue
  // ----------------------------------------
  localparam int DEPTH = 1 << QUEUE_AW;
  logic [15:0] queue_mem [DEPTH];
  logic [QUEUE_AW:0] wr_ptr;
  logic [QUEUE_AW:0] rd_ptr;
  wire [QUEUE_AW:0] fill = wr_ptr - rd_ptr;
  wire q_empty = (fill == '0);
  wire q_full = (fill == (QUEUE_AW + 1)'(DEPTH));
  wire push = msg_valid_i & ~q_full;
  wire [15:0] push_word = {msg_index_i, msg_readback_i, msg_data_i};
  wire [15:0] head_word = queue_mem[rd_ptr[QUEUE_AW-1:0]];

  // ----------------------------------------
  // frame state machine
  // ----------------------------------------
  scpi_state_t state;
  scpi_state_t next_state;
  logic [4:0] bit_cnt;
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic carrying;

  wire frame_done = (state == SCPI_SHIFT) & sel_rise & (bit_cnt == `SCPI_FRAME_BITS);
  wire frame_abort = (state == SCPI_SHIFT) & sel_rise & (bit_cnt != `SCPI_FRAME_BITS);
  wire pop = frame_done & carrying;
  wire [15:0] load_word = q_empty ? {`SCPI_IDLE_BYTE, `SCPI_IDLE_BYTE} : head_word;

  // ----------------------------------------
  // next state decode
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      SCPI_IDLE: begin
        if (sel_fall) begin
          next_state = SCPI_SHIFT;
        end
      end
      SCPI_SHIFT: begin
        if (sel_rise) begin
          next_state = SCPI_IDLE;
        end else if (!mode_s) begin
          next_state = SCPI_WAIT;
        end
      end
      SCPI_WAIT: begin
        if (sel_n_s) begin
          next_state = SCPI_IDLE;
        end
      end
      default: next_state = SCPI_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= SCPI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // bit counter and shift registers
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bit_cnt <= '0;
      rx_shift <= '0;
      tx_shift <= '0;
      carrying <= 1'b0;
    end else if (sel_fall && state == SCPI_IDLE) begin
      bit_cnt <= '0;
      tx_shift <= load_word;
      carrying <= ~q_empty;
    end else if (state == SCPI_SHIFT) begin
      if (sck_rise && bit_cnt != `SCPI_FRAME_BITS) begin
        rx_shift <= {rx_shift[14:0], sdi_s};
        bit_cnt <= bit_cnt + 5'd1;
      end
      if (sck_fall && bit_cnt != 5'd0) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // queue pointers
  // ----------------------------------------
  function automatic logic [QUEUE_AW:0] bump(input logic [QUEUE_AW:0] ptr);
    return ptr + 1'b1;
  endfunction : bump

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= bump(wr_ptr);
    end
  end

  // read pointer moves only on a complete frame
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= bump(rd_ptr);
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      queue_mem[wr_ptr[QUEUE_AW-1:0]] <= push_word;
    end
  end

  // ----------------------------------------
  // received field decode
  // ----------------------------------------
  function automatic scpi_index_t rx_index(input logic [15:0] word);
    return word[15:9];
  endfunction : rx_index

  function automatic logic rx_dir(input logic [15:0] word);
    return word[8];
  endfunction : rx_dir

  function automatic scpi_byte_t rx_content(input logic [15:0] word);
    return word[7:0];
  endfunction : rx_content

  wire frame_write = frame_done & (rx_dir(rx_shift) == `SCPI_DIR_WRITE);
  wire frame_readback = frame_done & (rx_dir(rx_shift) == `SCPI_DIR_READ);
  wire last_pop = pop & (fill == (QUEUE_AW + 1)'(1));
  wire oe_next = (next_state == SCPI_SHIFT);
  wire space_next = ~q_full & ~(msg_valid_i & (fill == (QUEUE_AW + 1)'(DEPTH - 1)));
  logic irq_blocked;
  // request withheld from select fall until select is high again
  wire irq_want = mode_s & sel_n_s & ~irq_blocked & ~sel_fall & ~(q_empty | last_pop);

  // ----------------------------------------
  // serial output pin
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_serial_out_o <= 1'b0;
      ctrl_serial_out_oe_o <= 1'b0;
    end else begin
      ctrl_serial_out_o <= tx_shift[15];
      ctrl_serial_out_oe_o <= oe_next;
    end
  end

  // ----------------------------------------
  // interrupt request
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_blocked <= 1'b0;
    end else if (sel_fall) begin
      irq_blocked <= 1'b1;
    end else if (sel_n_s) begin
      irq_blocked <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_n_out_o <= 1'b0;
      irq_n_oe_o <= 1'b0;
    end else begin
      irq_n_out_o <= 1'b0;
      irq_n_oe_o <= irq_want;
    end
  end

  // ----------------------------------------
  // strobes and fields to the device core
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_valid_o <= 1'b0;
      rb_req_valid_o <= 1'b0;
    end else begin
      wr_valid_o <= frame_write;
      rb_req_valid_o <= frame_readback;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_index_o <= '0;
      wr_data_o <= '0;
      rb_req_index_o <= '0;
    end else if (frame_done) begin
      wr_index_o <= rx_index(rx_shift);
      wr_data_o <= rx_content(rx_shift);
      rb_req_index_o <= rx_index(rx_shift);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      msg_ready_o <= 1'b0;
    end else begin
      msg_ready_o <= space_next;
    end
  end
endmodule : scpi_port

//--- dv/scpi_port_chk.sv
`timescale 1ns/1ps
module scpi_chk (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic port_type_select_i,
  input wire logic select_n_i,
  input wire logic ctrl_serial_out_oe_o,
  input wire logic irq_n_out_o,
  input wire logic irq_n_oe_o,
  input wire logic wr_valid_o,
  input wire logic rb_req_valid_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  out_release_a: assert property (select_n_i [*6] |-> !ctrl_serial_out_oe_o)
    else $error("serial out driven while unselected");
  irq_free_a: assert property (!select_n_i [*5] |-> !irq_n_oe_o)
    else $error("request held while selected");
  irq_latch_a: assert property ($fell(irq_n_oe_o) |-> !$past(select_n_i, 2))
    else $error("request dropped without select");
  drain_low_a: assert property (!irq_n_out_o)
    else $error("request pin not open drain");
  wr_pulse_a: assert property (wr_valid_o |=> !wr_valid_o)
    else $error("write strobe too long");
  rb_pulse_a: assert property (rb_req_valid_o |=> !rb_req_valid_o)
    else $error("read-back strobe too long");
  one_kind_a: assert property (!(wr_valid_o && rb_req_valid_o))
    else $error("write and read-back together");
  frame_end_a: assert property (wr_valid_o || rb_req_valid_o |-> $past(select_n_i, 3))
    else $error("strobe before frame end");
  port_off_a: assert property (!port_type_select_i [*8] |-> !wr_valid_o && !rb_req_valid_o)
    else $error("strobe while port disabled");
  cover property (wr_valid_o);
  cover property (rb_req_valid_o);
  cover property ($rose(irq_n_oe_o));
endmodule : scpi_chk

//--- dv/scpi_host.sv
`timescale 1ns/1ps
module scpi_host (
  input wire logic clock_i,
  input wire logic sdo_i,
  output logic select_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // n rising edges, msb first, line read late in the high phase
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge clock_i) select_n_o <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      sdi_o <= tx[i];
      repeat (4) @(negedge clock_i);
      sclk_o <= 1'b1;
      repeat (4) @(negedge clock_i);
      rx[i] = sdo_i;
      sclk_o <= 1'b0;
    end
    repeat (4) @(negedge clock_i);
    select_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (8) @(negedge clock_i);
  endtask : xfer
endmodule : scpi_host

//--- dv/tb_serial_control_port_irq.sv
`timescale 1ns/1ps
module tb_serial_control_port_irq;
  import scpi_pkg::*;
  logic clock_i, rst_n_i, port_type_select_i, select_n_i, ctrl_shift_clock_i;
  logic ctrl_serial_in_i, ctrl_serial_out_o, ctrl_serial_out_oe_o, irq_n_out_o;
  logic irq_n_oe_o, wr_valid_o, rb_req_valid_o, msg_valid_i, msg_readback_i, msg_ready_o;
  scpi_index_t wr_index_o, rb_req_index_o, msg_index_i;
  scpi_byte_t wr_data_o, msg_data_i;
  wire sdo_w = ctrl_serial_out_oe_o ? ctrl_serial_out_o : 1'bz;
  int err_count = 0, check_count = 0, wr_n = 0, rb_n = 0;
  logic [15:0] rx;
  scpi_port scpi_port_i (.*);
  scpi_host scpi_host_i (.clock_i, .sdo_i(sdo_w), .select_n_o(select_n_i),
    .sclk_o(ctrl_shift_clock_i), .sdi_o(ctrl_serial_in_i));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    wr_n += int'(wr_valid_o === 1'b1);
    rb_n += int'(rb_req_valid_o === 1'b1);
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic push(input logic rb, input scpi_index_t idx, input scpi_byte_t d);
    check(msg_ready_o, 1'b1);
    @(negedge clock_i) {msg_valid_i, msg_readback_i, msg_index_i, msg_data_i} <= {1'b1, rb, idx, d};
    @(negedge clock_i) msg_valid_i <= 1'b0;
  endtask : push
  task automatic wait_irq;
    int k;
    for (k = 0; k < 60 && irq_n_oe_o !== 1'b1; k++) @(negedge clock_i);
    check(k < 60, 1'b1);
    if (k == 60) wrap_up();
  endtask : wait_irq
  task automatic t_write;
    {wr_n, rb_n} = 0;
    scpi_host_i.xfer({7'h2A, 1'b0, 8'hC3}, 16, rx);
    check(rx, 16'h0000);
    check({wr_n[3:0], rb_n[3:0], wr_index_o, wr_data_o}, {8'h10, 7'h2A, 8'hC3});
  endtask : t_write
  task automatic t_readback;
    {wr_n, rb_n} = 0;
    scpi_host_i.xfer({7'h55, 1'b1, 8'hFF}, 16, rx);
    check({wr_n[3:0], rb_n[3:0], 1'b0, rb_req_index_o}, {8'h01, 8'h55});
  endtask : t_readback
  task automatic t_queue;
    push(1'b1, 7'h11, 8'hA5);
    push(1'b0, 7'h7F, 8'h3C);
    wait_irq();
    scpi_host_i.xfer(16'h0000, 16, rx);
    check(rx, {7'h11, 1'b1, 8'hA5});
    wait_irq();
    scpi_host_i.xfer(16'h0000, 16, rx);
    check(rx, {7'h7F, 1'b0, 8'h3C});
    check(irq_n_oe_o, 1'b0);
  endtask : t_queue
  task automatic t_short;
    push(1'b1, 7'h33, 8'h96);
    wait_irq();
    {wr_n, rb_n} = 0;
    scpi_host_i.xfer(16'h2A00, 8, rx);
    check(wr_n + rb_n, 16'h0000);
    wait_irq();
    scpi_host_i.xfer(16'h0000, 16, rx);
    check(rx, {7'h33, 1'b1, 8'h96});
  endtask : t_short
  task automatic t_disabled;
    {wr_n, rb_n} = 0;
    port_type_select_i <= 1'b0;
    scpi_host_i.xfer({7'h2A, 1'b0, 8'h5A}, 16, rx);
    check(rx, 16'hZZZZ);
    check(wr_n + rb_n, 16'h0000);
    port_type_select_i <= 1'b1;
    repeat (8) @(negedge clock_i);
  endtask : t_disabled
  initial begin
    rst_n_i = 1'b0;
    port_type_select_i = 1'b1;
    {msg_valid_i, msg_readback_i, msg_index_i, msg_data_i} = '0;
    repeat (8) @(negedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(negedge clock_i);
    t_write();
    t_readback();
    t_queue();
    t_short();
    t_disabled();
    wrap_up();
  end
endmodule : tb_serial_control_port_irq
bind scpi_port scpi_chk scpi_chk_i (.clock_i, .rst_n_i, .port_type_select_i, .select_n_i,
  .ctrl_serial_out_oe_o, .irq_n_out_o, .irq_n_oe_o, .wr_valid_o, .rb_req_valid_o);
